/* File: src/crem_top.sv */
// CSI-2 receive error monitor: link-side event capture, clock crossing,
// and the Wishbone-visible error and header capture registers.
// Assumes link-side receive logic on lnk_clk_i drives one-cycle event pulses.
//
// What this block does
// (RULE_01) Eight-bit errored-packet tally since last read; reading clears it.
// (RULE_02) Status bit 3 flags line shorter than header word count; clears on read.
// (RULE_03) Status bit 2 flags uncorrectable payload checksum error; clears on read.
// (RULE_04) Status bit 1 flags two-bit header ECC error; clears on read.
// (RULE_05) Status bit 0 flags one-bit header ECC error; clears on read.
// (RULE_06) Per lane SoT single-bit sync error; even lanes bit 3, odd bit 7.
// (RULE_07) Per lane SoT multi-bit sync error; even lanes bit 2, odd bit 6.
// (RULE_08) Per lane HS request control error; even lanes bit 1, odd bit 5.
// (RULE_09) Clock lane HS request control error in bit 1 of its register.
// (RULE_10) Captured virtual channel id shown in header register bits 7:6.
// (RULE_11) Captured data type id shown in header register bits 5:0.
// (RULE_12) Captured word count split into low and high byte registers.
// (RULE_13) Captured header ECC field in ECC register bits 5:0.
// (RULE_14) ECC register bit 7 flags a line length change within a frame.
// (RULE_15) Tally saturates at 255; one count per errored packet.
// (RULE_16) Header captures refresh on every new long packet header.
//
// Register access over Wishbone was left to the implementer.
`default_nettype none

module crem_top
  import crem_pkg::*;
(
  // Core clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Link side
  input wire logic lnk_clk_i,
  input wire crem_lnk_ev_t lnk_ev_i,
  input wire logic lnk_hdr_valid_i,
  input wire crem_hdr_t lnk_hdr_i
);

  // ---------------------------------------------------------------
  // Link domain reset
  // ---------------------------------------------------------------
  logic lrst_s1_q;
  logic lrst_q;

  always_ff @(posedge lnk_clk_i) begin
    lrst_s1_q <= rst_i;
    lrst_q <= lrst_s1_q;
  end

  // ---------------------------------------------------------------
  // Event crossing by toggles
  // ---------------------------------------------------------------
  // A repeat of the same event closer than one core cycle may cancel
  // out, so neither is seen; packets are far apart.
  logic [EV_W-1:0] ev_vec;
  logic [EV_W-1:0] ev_tog_q;
  logic [EV_W-1:0] ev_s1_q;
  logic [EV_W-1:0] ev_s2_q;
  logic [EV_W-1:0] ev_s3_q;
  logic [EV_W-1:0] ev_pulse;
  crem_lnk_ev_t ev_c;

  assign ev_vec = lnk_ev_i;

  for (genvar g = 0; g < EV_W; g++) begin : g_ev
    always_ff @(posedge lnk_clk_i) begin
      if (lrst_q) begin
        ev_tog_q[g] <= 1'b0;
      end else if (ev_vec[g]) begin
        ev_tog_q[g] <= ~ev_tog_q[g];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ev_s1_q[g] <= 1'b0;
        ev_s2_q[g] <= 1'b0;
        ev_s3_q[g] <= 1'b0;
      end else begin
        ev_s1_q[g] <= ev_tog_q[g];
        ev_s2_q[g] <= ev_s1_q[g];
        ev_s3_q[g] <= ev_s2_q[g];
      end
    end

    assign ev_pulse[g] = ev_s2_q[g] ^ ev_s3_q[g];
  end

  assign ev_c = ev_pulse;

  // ---------------------------------------------------------------
  // Header crossing
  // ---------------------------------------------------------------
  // Hold register stays still until the next header, so the core copies
  // it only after the toggle has settled through two flops.
  crem_hdr_t hdr_hold_q;
  logic hdr_tog_q;
  logic hdr_s1_q;
  logic hdr_s2_q;
  logic hdr_s3_q;
  logic hdr_evt;

  always_ff @(posedge lnk_clk_i) begin
    if (lrst_q) begin
      hdr_hold_q <= '0;
      hdr_tog_q <= 1'b0;
    end else if (lnk_hdr_valid_i) begin
      hdr_hold_q <= lnk_hdr_i;
      hdr_tog_q <= ~hdr_tog_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdr_s1_q <= 1'b0;
      hdr_s2_q <= 1'b0;
      hdr_s3_q <= 1'b0;
    end else begin
      hdr_s1_q <= hdr_tog_q;
      hdr_s2_q <= hdr_s1_q;
      hdr_s3_q <= hdr_s2_q;
    end
  end

  assign hdr_evt = hdr_s2_q ^ hdr_s3_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic ack_q;
  logic [DAT_W-1:0] dat_q;
  logic acc;
  logic [7:0] idx;
  logic rd_tally;
  logic rd_stat;
  logic wr_ctrl;
  logic flag_clr;
  logic [REG_W-1:0] rd_byte;

  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
  assign rd_tally = acc & ~wb_we_i & (idx == IDX_TALLY);
  assign rd_stat = acc & ~wb_we_i & (idx == IDX_STATUS);
  assign wr_ctrl = acc & wb_we_i & wb_sel_i[0] & (idx == IDX_CTRL);
  assign flag_clr = wr_ctrl & wb_dat_i[CTRL_CLR_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic cap_en_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_en_q <= CTRL_CAPEN_RST;
    end else if (wr_ctrl) begin
      cap_en_q <= wb_dat_i[CTRL_CAPEN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Errored packet tally
  // ---------------------------------------------------------------
  logic [REG_W-1:0] tally_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tally_q <= TALLY_RST;
    end else if (rd_tally) begin
      // A packet landing on the read edge starts the next count
      tally_q <= {{(REG_W-1){1'b0}}, ev_c.pkt_err}; // RULE_01
    end else if (ev_c.pkt_err && tally_q != TALLY_MAX) begin
      tally_q <= tally_q + 8'h01; // RULE_15
    end
  end

  // ---------------------------------------------------------------
  // Packet error status
  // ---------------------------------------------------------------
  logic [3:0] stat_q;
  logic [3:0] stat_set;

  always_comb begin
    stat_set = '0;
    stat_set[STAT_LINE_BIT] = ev_c.line_short; // RULE_02
    stat_set[STAT_CHK_BIT] = ev_c.chksum; // RULE_03
    stat_set[STAT_ECC2_BIT] = ev_c.ecc2; // RULE_04
    stat_set[STAT_ECC1_BIT] = ev_c.ecc1; // RULE_05
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else begin
      // Set beats the read clear
      stat_q <= (stat_q & ~{4{rd_stat}}) | stat_set; // RULE_02 RULE_03 RULE_04 RULE_05
    end
  end

  // ---------------------------------------------------------------
  // Lane and line length change error flags
  // ---------------------------------------------------------------
  // Read-only flags: sticky until software writes the clear bit.
  logic [NUM_LANES-1:0] sot1_q;
  logic [NUM_LANES-1:0] sotm_q;
  logic [NUM_LANES-1:0] hsc_q;
  logic clk_hsc_q;
  logic len_chg_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sot1_q <= '0;
    end else begin
      sot1_q <= (sot1_q & ~{NUM_LANES{flag_clr}}) | ev_c.sot_single; // RULE_06
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sotm_q <= '0;
    end else begin
      sotm_q <= (sotm_q & ~{NUM_LANES{flag_clr}}) | ev_c.sot_multi; // RULE_07
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hsc_q <= '0;
    end else begin
      hsc_q <= (hsc_q & ~{NUM_LANES{flag_clr}}) | ev_c.hs_ctrl; // RULE_08
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_hsc_q <= 1'b0;
    end else begin
      clk_hsc_q <= (clk_hsc_q & ~flag_clr) | ev_c.clk_hs_ctrl; // RULE_09
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_chg_q <= 1'b0;
    end else begin
      len_chg_q <= (len_chg_q & ~flag_clr) | ev_c.len_change; // RULE_14
    end
  end

  // ---------------------------------------------------------------
  // Header capture
  // ---------------------------------------------------------------
  crem_hdr_t hdr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdr_q <= '0;
    end else if (hdr_evt && cap_en_q) begin
      hdr_q <= hdr_hold_q; // RULE_10 RULE_11 RULE_12 RULE_13 RULE_16
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [1:0][REG_W-1:0] lane_reg;
  logic [REG_W-1:0] stat_reg;
  logic [REG_W-1:0] clk_reg;
  logic [REG_W-1:0] ecc_reg;
  logic [REG_W-1:0] ctrl_reg;

  always_comb begin
    lane_reg = '0;
    for (int l = 0; l < NUM_LANES; l++) begin
      lane_reg[l/2][(l%2)*LANE_ODD_SHIFT+LANE_SOT1_BIT] = sot1_q[l]; // RULE_06
      lane_reg[l/2][(l%2)*LANE_ODD_SHIFT+LANE_SOTM_BIT] = sotm_q[l]; // RULE_07
      lane_reg[l/2][(l%2)*LANE_ODD_SHIFT+LANE_HSC_BIT] = hsc_q[l]; // RULE_08
    end
  end

  always_comb begin
    stat_reg = '0;
    stat_reg[3:0] = stat_q;
    clk_reg = '0;
    clk_reg[CLK_HSC_BIT] = clk_hsc_q; // RULE_09
    ecc_reg = '0;
    ecc_reg[5:0] = hdr_q.ecc; // RULE_13
    ecc_reg[ECC_CHG_BIT] = len_chg_q; // RULE_14
    ctrl_reg = '0;
    ctrl_reg[CTRL_CAPEN_BIT] = cap_en_q;
  end

  always_comb begin
    unique case (idx)
      IDX_TALLY: rd_byte = tally_q;
      IDX_STATUS: rd_byte = stat_reg;
      IDX_LANE_LO: rd_byte = lane_reg[0];
      IDX_LANE_HI: rd_byte = lane_reg[1];
      IDX_CLK_LANE: rd_byte = clk_reg;
      IDX_HDR_CT: rd_byte = {hdr_q.vc, hdr_q.dt}; // RULE_10 RULE_11
      IDX_WC_LO: rd_byte = hdr_q.wc[7:0]; // RULE_12
      IDX_WC_HI: rd_byte = hdr_q.wc[15:8]; // RULE_12
      IDX_ECC: rd_byte = ecc_reg;
      IDX_CTRL: rd_byte = ctrl_reg;
      default: rd_byte = '0;
    endcase
  end

  // Read data taken before the clear lands, so software sees the old value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (acc && !wb_we_i) begin
      dat_q <= {{(DAT_W-REG_W){1'b0}}, rd_byte};
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_single_ack;
    ack_q ##1 !ack_q;
  endsequence

  sequence s_tally_read;
    rd_tally && !ev_c.pkt_err;
  endsequence

  AST_WB_ACK_ONE:
    assert property (@(posedge clk_i) disable iff (rst_i) acc |=> s_single_ack)
    else $error("ack not a single cycle after request");

  AST_TALLY_CLEAR: // RULE_01
    assert property (@(posedge clk_i) disable iff (rst_i) s_tally_read |=> (tally_q == TALLY_RST) ##1 (wb_dat_o[7:0] == $past(tally_q, 2)))
    else $error("tally not cleared by read or old value lost");

  AST_TALLY_STEP: // RULE_15
    assert property (@(posedge clk_i) disable iff (rst_i)
      (ev_c.pkt_err && !rd_tally && tally_q != TALLY_MAX) |=> tally_q == $past(tally_q) + 8'h01)
    else $error("tally did not step by one");

  AST_TALLY_SAT: // RULE_15
    assert property (@(posedge clk_i) disable iff (rst_i) (tally_q == TALLY_MAX && !rd_tally) |=> tally_q == TALLY_MAX)
    else $error("tally wrapped past maximum");

  AST_STAT_SET: // RULE_02 RULE_03 RULE_04 RULE_05
    assert property (@(posedge clk_i) disable iff (rst_i) (|stat_set) |=> ((stat_q & $past(stat_set)) == $past(stat_set)))
    else $error("status flag lost its event");

  AST_STAT_CLEAR: // RULE_02 RULE_03 RULE_04 RULE_05
    assert property (@(posedge clk_i) disable iff (rst_i) (rd_stat && stat_set == '0) |=> stat_q == '0)
    else $error("status not cleared by read");

  AST_LANE_SET: // RULE_06 (lane 1 single-bit sync only)
    assert property (@(posedge clk_i) disable iff (rst_i)
      ev_c.sot_single[1] |=> lane_reg[0][LANE_ODD_SHIFT+LANE_SOT1_BIT] && sot1_q[1])
    else $error("odd lane sync flag not in its bit");

  AST_LANE_HOLD: // RULE_07 RULE_08
    assert property (@(posedge clk_i) disable iff (rst_i)
      (sotm_q[2] && hsc_q[3] && !flag_clr) |=> (lane_reg[1][LANE_SOTM_BIT] && lane_reg[1][LANE_ODD_SHIFT+LANE_HSC_BIT]))
    else $error("lane flag dropped without clear");

  AST_CLK_LANE: // RULE_09
    assert property (@(posedge clk_i) disable iff (rst_i) ev_c.clk_hs_ctrl |=> clk_reg[CLK_HSC_BIT])
    else $error("clock lane control flag not set");

  AST_HDR_CAPT: // RULE_10 RULE_11 RULE_12 RULE_13 RULE_16
    assert property (@(posedge clk_i) disable iff (rst_i)
      (hdr_evt && cap_en_q) |=> (hdr_q == $past(hdr_hold_q)) && (ecc_reg[5:0] == $past(hdr_hold_q.ecc)))
    else $error("header fields not captured");

  AST_LEN_CHG: // RULE_14
    assert property (@(posedge clk_i) disable iff (rst_i) ev_c.len_change |=> ecc_reg[ECC_CHG_BIT] [*2] or flag_clr)
    else $error("length change flag not held");

endmodule : crem_top

`default_nettype wire

/* File: shared/crem_pkg.sv */
// Constants and carrier types for the CSI-2 receive error monitor.
// Assumes the register window is reached by word index over a 32-bit bus.
`default_nettype none

package crem_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int REG_W = 8;
  localparam int IDX_LSB = 2;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_TALLY = 8'h5C;
  localparam logic [7:0] IDX_STATUS = 8'h5D;
  localparam logic [7:0] IDX_LANE_LO = 8'h5E;
  localparam logic [7:0] IDX_LANE_HI = 8'h5F;
  localparam logic [7:0] IDX_CLK_LANE = 8'h60;
  localparam logic [7:0] IDX_HDR_CT = 8'h61;
  localparam logic [7:0] IDX_WC_LO = 8'h62;
  localparam logic [7:0] IDX_WC_HI = 8'h63;
  localparam logic [7:0] IDX_ECC = 8'h64;
  localparam logic [7:0] IDX_CTRL = 8'h65;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int STAT_LINE_BIT = 3;
  localparam int STAT_CHK_BIT = 2;
  localparam int STAT_ECC2_BIT = 1;
  localparam int STAT_ECC1_BIT = 0;
  localparam int LANE_SOT1_BIT = 3;
  localparam int LANE_SOTM_BIT = 2;
  localparam int LANE_HSC_BIT = 1;
  localparam int LANE_ODD_SHIFT = 4;
  localparam int CLK_HSC_BIT = 1;
  localparam int ECC_CHG_BIT = 7;
  localparam int CTRL_CAPEN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic [7:0] TALLY_RST = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hFF;
  localparam logic CTRL_CAPEN_RST = 1'b1;
  localparam int NUM_LANES = 4;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pkt_err;
    logic len_change;
    logic line_short;
    logic chksum;
    logic ecc2;
    logic ecc1;
    logic [NUM_LANES-1:0] sot_single;
    logic [NUM_LANES-1:0] sot_multi;
    logic [NUM_LANES-1:0] hs_ctrl;
    logic clk_hs_ctrl;
  } crem_lnk_ev_t;

  localparam int EV_W = $bits(crem_lnk_ev_t);

  typedef struct packed {
    logic [1:0] vc;
    logic [5:0] dt;
    logic [15:0] wc;
    logic [5:0] ecc;
  } crem_hdr_t;

endpackage : crem_pkg

`default_nettype wire

/* File: sim/crem_lnk_model.sv */
// Behavioural image sensor transmitter facing the error monitor link side.
// Assumes the bench supplies the link clock and calls the send tasks.
`default_nettype none

module crem_lnk_model
  import crem_pkg::*;
(
  // Link clock
  input wire logic lnk_clk_i,
  // Link events and header
  output crem_lnk_ev_t lnk_ev_o,
  output logic lnk_hdr_valid_o,
  output crem_hdr_t lnk_hdr_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    lnk_ev_o = '0;
    lnk_hdr_valid_o = 1'b0;
    lnk_hdr_o = '0;
  end

  // ---------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------
  // Gap of 8 link cycles keeps packets over 32 ns apart
  task automatic send_ev(input crem_lnk_ev_t ev);
    @(posedge lnk_clk_i);
    lnk_ev_o <= ev;
    @(posedge lnk_clk_i);
    lnk_ev_o <= '0;
    repeat (8) @(posedge lnk_clk_i);
  endtask : send_ev

  // Header held past the capture window, then scrambled so stale data is never read
  task automatic send_hdr(input crem_hdr_t hdr);
    @(posedge lnk_clk_i);
    lnk_hdr_o <= hdr;
    lnk_hdr_valid_o <= 1'b1;
    @(posedge lnk_clk_i);
    lnk_hdr_valid_o <= 1'b0;
    repeat (6) @(posedge lnk_clk_i);
    lnk_hdr_o <= ~hdr;
    repeat (2) @(posedge lnk_clk_i);
  endtask : send_hdr

endmodule : crem_lnk_model

`default_nettype wire

/* File: sim/test_crem_top.sv */
// Self-checking bench for the CSI-2 receive error monitor.
// Assumes the link model drives the link side and Wishbone reaches the registers.
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %0t read %h expected %h", $time, got, exp); end end

module test_crem_top
  import crem_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i;
  logic rst_i;
  logic lnk_clk_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [ADR_W-1:0] wb_adr_i;
  logic [SEL_W-1:0] wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  crem_lnk_ev_t lnk_ev;
  logic lnk_hdr_valid;
  crem_hdr_t lnk_hdr;
  int miscompares;
  int comparisons;
  int i;
  int k;
  logic [EV_W-1:0] v;
  logic [7:0] acc [2];
  crem_hdr_t hs [2];

  crem_top u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .lnk_clk_i(lnk_clk_i),
    .lnk_ev_i(lnk_ev),
    .lnk_hdr_valid_i(lnk_hdr_valid),
    .lnk_hdr_i(lnk_hdr)
  );

  crem_lnk_model u_lnk (
    .lnk_clk_i(lnk_clk_i),
    .lnk_ev_o(lnk_ev),
    .lnk_hdr_valid_o(lnk_hdr_valid),
    .lnk_hdr_o(lnk_hdr)
  );

  // ---------------------------------------------------------------
  // Clocks and run control
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Odd offset keeps the link edges away from the core edges
  initial begin
    lnk_clk_i = 1'b0;
    #1.7;
    forever #3 lnk_clk_i = ~lnk_clk_i;
  end

  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Wishbone classic master
  // ---------------------------------------------------------------
  task automatic wb_acc(input logic we, input logic [7:0] idx, input logic [7:0] d,
                        input logic [3:0] sel, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_acc

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    wb_acc(1'b0, idx, 8'h00, 4'hF, q);
    `CHK(q, {24'h000000, exp})
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel);
    logic [31:0] q;
    wb_acc(1'b1, idx, d, sel, q);
  endtask : wr

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = '0;
    wb_dat_i = '0;
    hs[0] = '{vc: 2'h2, dt: 6'h2B, wc: 16'h1234, ecc: 6'h15};
    hs[1] = '{vc: 2'h1, dt: 6'h12, wc: 16'hA5C3, ecc: 6'h2A};
    acc[0] = 8'h00;
    acc[1] = 8'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 9; i++) rd(8'(IDX_TALLY + i), 8'h00);
    rd(IDX_CTRL, 8'h01);
    // Unmapped place and read-only write
    rd(8'h70, 8'h00);
    wr(IDX_HDR_CT, 8'hFF, 4'hF);
    rd(IDX_HDR_CT, 8'h00);
    // Each packet flag alone, then cleared by its read
    for (i = 0; i < 4; i++) begin
      v = '0;
      v[EV_W-1] = 1'b1;
      v[13+i] = 1'b1;
      u_lnk.send_ev(v);
      rd(IDX_STATUS, 8'(1 << i));
      rd(IDX_STATUS, 8'h00);
      rd(IDX_TALLY, 8'h01);
      rd(IDX_TALLY, 8'h00);
    end
    // Several kinds in one packet still count once
    v = '0;
    v[EV_W-1] = 1'b1;
    v[15:13] = 3'b111;
    u_lnk.send_ev(v);
    rd(IDX_TALLY, 8'h01);
    rd(IDX_STATUS, 8'h07);
    // Lane flags accumulate per kind and lane
    for (i = 0; i < 4; i++) begin
      for (k = 0; k < 3; k++) begin
        v = '0;
        v[9-4*k+i] = 1'b1;
        u_lnk.send_ev(v);
        acc[i/2] = acc[i/2] | 8'(1 << (4 * (i % 2) + 3 - k));
        rd(8'(IDX_LANE_LO + i / 2), acc[i/2]);
      end
    end
    rd(IDX_TALLY, 8'h00);
    v = '0;
    v[0] = 1'b1;
    u_lnk.send_ev(v);
    rd(IDX_CLK_LANE, 8'h02);
    v = '0;
    v[17] = 1'b1;
    u_lnk.send_ev(v);
    rd(IDX_ECC, 8'h80);
    rd(IDX_ECC, 8'h80);
    // Sticky flags cleared only through the control register
    wr(IDX_CTRL, 8'h03, 4'hF);
    rd(IDX_LANE_HI, 8'h00);
    rd(IDX_CLK_LANE, 8'h00);
    rd(IDX_ECC, 8'h00);
    rd(IDX_CTRL, 8'h01);
    // Header capture follows the newest long packet
    for (i = 0; i < 2; i++) begin
      u_lnk.send_hdr(hs[i]);
      rd(IDX_HDR_CT, {hs[i].vc, hs[i].dt});
      rd(IDX_WC_LO, hs[i].wc[7:0]);
      rd(IDX_WC_HI, hs[i].wc[15:8]);
      rd(IDX_ECC, {2'b00, hs[i].ecc});
    end
    wr(IDX_CTRL, 8'h00, 4'hF);
    u_lnk.send_hdr(hs[0]);
    rd(IDX_WC_LO, hs[1].wc[7:0]);
    wr(IDX_CTRL, 8'h01, 4'h0);
    rd(IDX_CTRL, 8'h00);
    // Tally saturates instead of wrapping
    v = '0;
    v[EV_W-1] = 1'b1;
    repeat (260) u_lnk.send_ev(v);
    rd(IDX_TALLY, 8'hFF);
    rd(IDX_TALLY, 8'h00);
    wrap_up();
  end

endmodule : test_crem_top

`default_nettype wire
